/* File: design/owm_pkg.sv */
`default_nettype none
// ==========================================================
// shared constants for the single-wire identity and memory map
package owm_pkg;
    // identity code layout
    localparam int ID_BITS = 64;
    localparam int DATA_BITS = 56;
    localparam int FAMILY_BITS = 8;
    localparam int SERIAL_BITS = 48;
    // x^8 + x^5 + x^4 + 1 taken lsb first (reflected form)
    localparam logic [7:0] CRC_POLY = 8'h8c;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // rom function command codes (eight of them)
    localparam logic [7:0] ROM_READ = 8'h01;
    localparam logic [7:0] ROM_MATCH = 8'h02;
    localparam logic [7:0] ROM_SEARCH = 8'h03;
    localparam logic [7:0] ROM_CSEARCH = 8'h04;
    localparam logic [7:0] ROM_SKIP = 8'h05;
    localparam logic [7:0] ROM_OD_SKIP = 8'h06;
    localparam logic [7:0] ROM_OD_MATCH = 8'h07;
    localparam logic [7:0] ROM_RESUME = 8'h08;
    // memory map, 32-byte pages
    localparam int PAGE_SHIFT = 5;
    localparam int PAGE_BYTES = 32;
    localparam logic [8:0] PG_REG1 = 9'h010;
    localparam logic [8:0] PG_REG2 = 9'h011;
    localparam logic [8:0] PG_CAL1 = 9'h012;
    localparam logic [8:0] PG_CAL2 = 9'h013;
    localparam logic [8:0] PG_RSV_LO = 9'h014;
    localparam logic [8:0] PG_RSV_HI = 9'h07f;
    localparam logic [8:0] PG_LOG = 9'h080;
    localparam logic [8:0] LOG_PAGES = 9'h100;
    localparam int GP_BYTES = 640;
    localparam int LOG_BYTES = 8192;
    // password bytes inside the second register page
    localparam logic [15:0] PW_LO = 16'h0227;
    localparam logic [15:0] PW_HI = 16'h0236;
    typedef enum logic [2:0] {
        RG_GP = 3'h0, RG_REG = 3'h1, RG_RSV = 3'h2, RG_LOG = 3'h3,
        RG_NONE = 3'h4
    } owm_region_t;
    typedef enum logic [5:0] {
        ST_CRC = 6'b000001, ST_ROMCMD = 6'b000010, ST_ROMTX = 6'b000100,
        ST_ROMRX = 6'b001000, ST_FUNC = 6'b010000, ST_IDLE = 6'b100000
    } owm_state_t;

    // one bit of the identity crc generator
    function automatic logic [7:0] owm_crc_bit(logic [7:0] c, logic b);
        logic fb;
        fb = c[0] ^ b;
        owm_crc_bit = (c >> 1) ^ (fb ? CRC_POLY : CRC_INIT);
    endfunction : owm_crc_bit

    // a whole byte, lsb first
    function automatic logic [7:0] owm_crc_byte(logic [7:0] c,
                                                logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = owm_crc_bit(r, d[i]);
        end
        owm_crc_byte = r;
    endfunction : owm_crc_byte

    // page number and region of a byte address
    function automatic owm_region_t owm_region(logic [15:0] a);
        logic [8:0] pg;
        pg = a[13:5];
        if (a[15:14] != 2'h0) owm_region = RG_NONE;
        else if (pg < PG_REG1) owm_region = RG_GP;
        else if (pg <= PG_REG2) owm_region = RG_REG;
        else if (pg <= PG_CAL2) owm_region = RG_GP;
        else if (pg <= PG_RSV_HI) owm_region = RG_RSV;
        else if (pg < PG_LOG + LOG_PAGES) owm_region = RG_LOG;
        else owm_region = RG_NONE;
    endfunction : owm_region
endpackage : owm_pkg
`default_nettype wire

/* File: design/owm_core.sv */
`default_nettype none
// Behaviour
// R01: identity is family byte, 48-bit serial, then crc over first 56 bits.
// R02: crc generator is xor-fed shift register for x^8+x^5+x^4+1.
// R03: crc starts at zero, bits enter one at a time, family lsb first.
// R04: serial bits follow; register then equals the crc.
// R05: shifting the eight crc bits in returns the register to zero.
// R06: master issues a rom command before any memory or control command.
// R07: overdrive rom command received at standard speed enters overdrive.
// R08: function commands accepted only after a rom command succeeds.
// R09: every byte on the link travels least significant bit first.
// R10: register page writes rejected while a mission is programmed.
// R11: password bytes accept writes but always read back as zero.
// R12: datalog is read-only from the link; only internal logic writes.
// R13: all memories except rom and scratchpad share one address space.
// R14: sram fills pages 0 to 15, register pages are 16 and 17.
// R15: datalog begins at 1000h, page 128, and spans 256 pages.
// R16: pages 20 through 127 are reserved with no function.
// R17: a 32-byte scratchpad stages every write to sram or registers.
// R18: last calibration byte holds crc over the preceding 31 bytes.
// R19: page 19 duplicates page 18; both stay writable.
// R20: general-purpose memory is writable whatever the mission state.
// R21: master should write whole pages through the scratchpad.
// R22: pages are 32 bytes; page is byte address shifted right five.
module owm_core #(
    parameter logic [7:0] FAMILY = 8'h5a,      // arbitrary value
    parameter logic [47:0] SERIAL = 48'h0123_4567_89ab // arbitrary value
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic bus_reset,
    input wire logic bus_reset_std,
    input wire logic rx_valid,
    input wire logic rx_bit,
    input wire logic tx_req,
    output logic tx_valid,
    output logic tx_bit,
    output logic overdrive,
    output logic rom_done,
    output logic id_crc_ok,
    output logic [7:0] id_crc,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    input wire logic mission_active,
    input wire logic spad_wr,
    input wire logic [4:0] spad_off,
    input wire logic [7:0] spad_data,
    input wire logic copy_req,
    input wire logic [8:0] copy_page,
    output logic copy_busy,
    output logic copy_err,
    output logic cal_crc_ok,
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic log_wr,
    input wire logic [12:0] log_addr,
    input wire logic [7:0] log_data
);
    // ==========================================================
    // state
    typedef struct packed {
        owm_pkg::owm_state_t st;
        logic [7:0] crc;
        logic [6:0] cnt;
        logic [7:0] sh;
        logic [2:0] bitn;
        logic [7:0] id_crc;
        logic id_crc_ok;
        logic od;
        logic selected;
        logic mismatch;
        logic odm;
        logic rom_done;
        logic cmd_valid;
        logic [7:0] cmd_byte;
        logic tx_valid;
        logic tx_bit;
        logic cp_busy;
        logic [4:0] cp_idx;
        logic [8:0] cp_page;
        logic cp_err;
        logic [7:0] cal_crc;
        logic cal_ok;
        logic rd_valid;
    } owm_core_state_t;

    owm_core_state_t s;
    owm_core_state_t next_s;
    logic [63:0] id_word;
    logic [7:0] rx_byte;
    logic [7:0] gp_mem [owm_pkg::GP_BYTES];
    logic [7:0] log_mem [owm_pkg::LOG_BYTES];
    logic [7:0] spad [owm_pkg::PAGE_BYTES];
    logic copy_ok;
    logic cp_last;
    logic [15:0] log_off;

    // stored identity; crc byte is the one the generator produced
    assign id_word = {s.id_crc, SERIAL, FAMILY}; // R01
    assign rx_byte = {rx_bit, s.sh[7:1]}; // R09
    assign cp_last = (s.cp_idx == 5'h1f);
    // datalog byte offset from the start of its first page
    assign log_off = rd_addr - 16'({owm_pkg::PG_LOG, 5'h00}); // R15
    // copy target must be gp or an unlocked register page
    assign copy_ok = (copy_page <= owm_pkg::PG_CAL2) &&
        !(mission_active && (copy_page == owm_pkg::PG_REG1 ||
          copy_page == owm_pkg::PG_REG2)); // R10 R20

    // ==========================================================
    // next-state logic
    always_comb begin
        next_s = s;
        next_s.cmd_valid = 1'b0;
        next_s.tx_valid = 1'b0;
        next_s.cp_err = 1'b0;
        next_s.rd_valid = rd_req;
        // link bit assembly, lsb first
        if (rx_valid) begin
            next_s.sh = rx_byte; // R09
            next_s.bitn = s.bitn + 3'h1;
        end
        case (s.st)
            owm_pkg::ST_CRC: begin
                // self-generate crc, then run it back through to check
                next_s.crc = owm_pkg::owm_crc_bit(s.crc,
                    (s.cnt < 7'd56) ? id_word[s.cnt[5:0]] :
                    s.crc[0]); // R02 R03 R04
                if (s.cnt == 7'd55) begin
                    next_s.id_crc = owm_pkg::owm_crc_bit(s.crc,
                        id_word[55]); // R04
                end
                next_s.cnt = s.cnt + 7'h1;
                if (s.cnt == 7'd63) begin
                    next_s.id_crc_ok = (owm_pkg::owm_crc_bit(s.crc,
                        s.id_crc[7]) == owm_pkg::CRC_INIT); // R05
                    next_s.st = owm_pkg::ST_ROMCMD;
                    next_s.bitn = 3'h0;
                end
            end
            owm_pkg::ST_ROMCMD: begin
                if (rx_valid && s.bitn == 3'h7) begin
                    next_s.cnt = 7'h0;
                    next_s.mismatch = 1'b0;
                    next_s.odm = (rx_byte == owm_pkg::ROM_OD_MATCH);
                    case (rx_byte)
                        owm_pkg::ROM_READ: begin
                            next_s.st = owm_pkg::ST_ROMTX;
                            next_s.selected = 1'b0;
                        end
                        owm_pkg::ROM_MATCH,
                        owm_pkg::ROM_OD_MATCH: begin
                            next_s.st = owm_pkg::ST_ROMRX;
                            if (rx_byte == owm_pkg::ROM_OD_MATCH) begin
                                next_s.od = 1'b1; // R07
                            end
                        end
                        owm_pkg::ROM_SKIP,
                        owm_pkg::ROM_OD_SKIP: begin
                            next_s.st = owm_pkg::ST_FUNC; // R08
                            next_s.rom_done = 1'b1;
                            next_s.selected = 1'b0;
                            if (rx_byte == owm_pkg::ROM_OD_SKIP) begin
                                next_s.od = 1'b1; // R07
                            end
                        end
                        owm_pkg::ROM_RESUME: begin
                            next_s.st = s.selected ? owm_pkg::ST_FUNC :
                                owm_pkg::ST_IDLE;
                            next_s.rom_done = s.selected; // R08
                        end
                        default: begin
                            // search forms and unknown codes: wait reset
                            next_s.st = owm_pkg::ST_IDLE; // R06
                        end
                    endcase
                end
            end
            owm_pkg::ST_ROMTX: begin
                // identity sent lsb first on each read slot
                if (tx_req) begin
                    next_s.tx_valid = 1'b1;
                    next_s.tx_bit = id_word[s.cnt[5:0]]; // R09
                    next_s.cnt = s.cnt + 7'h1;
                    if (s.cnt == 7'd63) begin
                        next_s.st = owm_pkg::ST_FUNC;
                        next_s.rom_done = 1'b1; // R08
                        next_s.bitn = 3'h0;
                    end
                end
            end
            owm_pkg::ST_ROMRX: begin
                // compare incoming identity bit by bit
                if (rx_valid) begin
                    next_s.cnt = s.cnt + 7'h1;
                    if (s.cnt == 7'd63) begin
                        if (s.mismatch || rx_bit != id_word[63]) begin
                            next_s.st = owm_pkg::ST_IDLE;
                        end else begin
                            next_s.st = owm_pkg::ST_FUNC;
                            next_s.rom_done = 1'b1; // R08
                            next_s.selected = 1'b1;
                        end
                    end else if (rx_bit != id_word[s.cnt[5:0]]) begin
                        next_s.mismatch = 1'b1;
                    end
                end
            end
            owm_pkg::ST_FUNC: begin
                // hand function command bytes to the memory layer
                if (rx_valid && s.bitn == 3'h7) begin
                    next_s.cmd_valid = 1'b1; // R08
                    next_s.cmd_byte = rx_byte;
                end
            end
            owm_pkg::ST_IDLE: begin
                next_s.rom_done = 1'b0;
            end
            default: begin
                next_s.st = owm_pkg::ST_IDLE;
            end
        endcase
        // a link reset restarts the rom layer; standard one leaves od
        if (bus_reset && s.st != owm_pkg::ST_CRC) begin
            next_s.st = owm_pkg::ST_ROMCMD; // R06
            next_s.bitn = 3'h0;
            next_s.rom_done = 1'b0;
            next_s.cmd_valid = 1'b0;
            if (bus_reset_std) begin
                next_s.od = 1'b0;
            end
        end
        // scratchpad copy, one byte a cycle, calibration crc on the fly
        if (s.cp_busy) begin
            next_s.cp_idx = s.cp_idx + 5'h1;
            if (!cp_last) begin
                next_s.cal_crc = owm_pkg::owm_crc_byte(s.cal_crc,
                    spad[s.cp_idx]); // R18
            end else begin
                next_s.cp_busy = 1'b0;
                if (s.cp_page == owm_pkg::PG_CAL1 ||
                    s.cp_page == owm_pkg::PG_CAL2) begin
                    next_s.cal_ok = (spad[s.cp_idx] == s.cal_crc); // R18
                end
            end
        end else if (copy_req) begin
            next_s.cp_busy = copy_ok; // R17
            next_s.cp_err = !copy_ok; // R10
            next_s.cp_page = copy_page;
            next_s.cp_idx = 5'h0;
            next_s.cal_crc = owm_pkg::CRC_INIT;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s <= '0;
            s.st <= owm_pkg::ST_CRC;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // memories: one linear space plus scratchpad
    always_ff @(posedge core_clk) begin
        if (spad_wr && !s.cp_busy) begin
            spad[spad_off] <= spad_data;
        end
        if (s.cp_busy) begin
            gp_mem[{s.cp_page[4:0], s.cp_idx}] <= spad[s.cp_idx]; // R17
            if (s.cp_page == owm_pkg::PG_CAL1) begin
                gp_mem[{owm_pkg::PG_CAL2[4:0], s.cp_idx}] <=
                    spad[s.cp_idx]; // R19
            end
        end
        if (log_wr) begin
            log_mem[log_addr] <= log_data; // R12
        end
        if (rd_req) begin
            case (owm_pkg::owm_region(rd_addr)) // R13 R14 R15 R16 R22
                owm_pkg::RG_GP: rd_data <= gp_mem[rd_addr[9:0]];
                owm_pkg::RG_REG: begin
                    rd_data <= (rd_addr >= owm_pkg::PW_LO &&
                        rd_addr <= owm_pkg::PW_HI) ? 8'h00 :
                        gp_mem[rd_addr[9:0]]; // R11
                end
                owm_pkg::RG_LOG: rd_data <= log_mem[log_off[12:0]];
                default: rd_data <= 8'h00;
            endcase
        end
        if (srst) begin
            rd_data <= 8'h00;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign tx_valid = s.tx_valid;
    assign tx_bit = s.tx_bit;
    assign overdrive = s.od;
    assign rom_done = s.rom_done;
    assign id_crc_ok = s.id_crc_ok;
    assign id_crc = s.id_crc;
    assign cmd_valid = s.cmd_valid;
    assign cmd_byte = s.cmd_byte;
    assign copy_busy = s.cp_busy;
    assign copy_err = s.cp_err;
    assign cal_crc_ok = s.cal_ok;
    assign rd_valid = s.rd_valid;

    // ==========================================================
    // checks
    property p_crc_done;
        @(posedge core_clk) disable iff (srst)
        (s.st == owm_pkg::ST_CRC && s.cnt == 7'd63) |=> s.id_crc_ok;
    endproperty
    a_crc_done: assert property (p_crc_done) // R05
        else $error("identity crc did not check to zero");
    property p_no_cmd_before_rom;
        @(posedge core_clk) disable iff (srst)
        cmd_valid |-> $past(s.st) == owm_pkg::ST_FUNC && rom_done;
    endproperty
    a_no_cmd_before_rom: assert property (p_no_cmd_before_rom) // R08
        else $error("function command outside function stage");
    property p_od_enter;
        @(posedge core_clk) disable iff (srst)
        (s.st == owm_pkg::ST_ROMCMD && rx_valid && s.bitn == 3'h7 &&
         rx_byte == owm_pkg::ROM_OD_SKIP && !bus_reset) |=> overdrive;
    endproperty
    a_od_enter: assert property (p_od_enter) // R07
        else $error("overdrive not entered");
    property p_reg_lock;
        @(posedge core_clk) disable iff (srst)
        (copy_req && !s.cp_busy && mission_active &&
         copy_page == owm_pkg::PG_REG1) |=> copy_err && !copy_busy;
    endproperty
    a_reg_lock: assert property (p_reg_lock) // R10
        else $error("register page copy not refused in mission");
    property p_gp_free;
        @(posedge core_clk) disable iff (srst)
        (copy_req && !s.cp_busy && copy_page < owm_pkg::PG_REG1)
        |=> copy_busy [*8];
    endproperty
    a_gp_free: assert property (p_gp_free) // R20
        else $error("general copy refused");
    property p_pw_hidden;
        @(posedge core_clk) disable iff (srst)
        (rd_req && rd_addr >= owm_pkg::PW_LO && rd_addr <= owm_pkg::PW_HI)
        |=> rd_valid && rd_data == 8'h00;
    endproperty
    a_pw_hidden: assert property (p_pw_hidden) // R11
        else $error("password byte readable");
    property p_rsv_zero;
        @(posedge core_clk) disable iff (srst)
        (rd_req && rd_addr >= 16'h0280 && rd_addr < 16'h1000)
        |=> rd_data == 8'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) // R16
        else $error("reserved page returned data");
    property p_copy_len;
        @(posedge core_clk) disable iff (srst)
        $rose(copy_busy) |-> copy_busy [*8] ##24 copy_busy ##1 !copy_busy;
    endproperty
    a_copy_len: assert property (p_copy_len) // R17
        else $error("copy not one page long");
    property p_tx_lsb;
        @(posedge core_clk) disable iff (srst)
        (s.st == owm_pkg::ST_ROMTX && tx_req && s.cnt == 7'd0)
        |=> tx_valid && tx_bit == FAMILY[0];
    endproperty
    a_tx_lsb: assert property (p_tx_lsb) // R09
        else $error("identity not sent lsb first");
    c_read_rom: cover property (@(posedge core_clk)
        s.st == owm_pkg::ST_ROMTX ##[1:200] s.st == owm_pkg::ST_FUNC);
    c_match: cover property (@(posedge core_clk)
        s.st == owm_pkg::ST_ROMRX ##[1:200] s.selected);
    c_cal_copy: cover property (@(posedge core_clk)
        $fell(copy_busy) ##1 cal_crc_ok);
endmodule : owm_core
`default_nettype wire

/* File: verification/owm_host.sv */
`default_nettype none
// ==========================================================
// single-wire master model driving the core's bit-level port
module owm_host (
    input wire logic core_clk,
    output logic bus_reset,
    output logic bus_reset_std,
    output logic rx_valid,
    output logic rx_bit,
    output logic tx_req,
    input wire logic tx_valid,
    input wire logic tx_bit
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle link at time zero
    initial begin
        bus_reset = 1'b0;
        bus_reset_std = 1'b0;
        rx_valid = 1'b0;
        rx_bit = 1'b1;
        tx_req = 1'b0;
    end

    // one link reset pulse, std marks a standard length one
    task automatic link_reset(input logic std);
        @(posedge core_clk);
        bus_reset <= 1'b1;
        bus_reset_std <= std;
        @(posedge core_clk);
        bus_reset <= 1'b0;
        bus_reset_std <= 1'b0;
    endtask : link_reset

    // a byte lsb first; the idle line shows the inverse of the last bit
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_bit <= b[i];
        end
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_bit <= ~b[7];
    endtask : send_byte

    // read 64 identity bits and run the receiver's own crc over them
    task automatic read_id(output logic [63:0] id, output logic ok);
        logic [7:0] c;
        logic got;
        c = 8'h00;
        ok = 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(posedge core_clk);
            tx_req <= 1'b1;
            @(posedge core_clk);
            tx_req <= 1'b0;
            got = 1'b0;
            for (int n = 0; n < 4 && !got; n++) begin
                #1;
                if (tx_valid === 1'b1) begin
                    got = 1'b1;
                    id[i] = tx_bit;
                end else begin
                    @(posedge core_clk);
                end
            end
            ok = ok & got;
            c = (c >> 1) ^ ((c[0] ^ id[i]) ? 8'h8c : 8'h00);
        end
        ok = ok & (c === 8'h00);
    endtask : read_id
endmodule : owm_host
`default_nettype wire

/* File: verification/onewire_rom_id_and_memory_map_tb_top.sv */
`default_nettype none
// ==========================================================
// self-checking bench for the identity and memory map core
module onewire_rom_id_and_memory_map_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] FAM = 8'h3c; // arbitrary value
    localparam logic [47:0] SER = 48'h00a1_b2c3_d4e5; // arbitrary value
    typedef struct packed {
        logic [15:0] a;
        logic [7:0] d;
    } owm_row_t;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic bus_reset, bus_reset_std, rx_valid, rx_bit, tx_req;
    logic tx_valid, tx_bit, overdrive, rom_done, id_crc_ok, cmd_valid;
    logic copy_busy, copy_err, cal_crc_ok, rd_valid;
    logic [7:0] id_crc, cmd_byte, rd_data;
    logic mission_active = 1'b0, spad_wr = 1'b0, copy_req = 1'b0;
    logic rd_req = 1'b0, log_wr = 1'b0;
    logic [4:0] spad_off = 5'h00;
    logic [7:0] spad_data = 8'h00, log_data = 8'h00;
    logic [8:0] copy_page = 9'h000;
    logic [15:0] rd_addr = 16'h0000;
    logic [12:0] log_addr = 13'h0000;
    int fails = 0, samples_checked = 0, cmd_seen = 0;
    owm_row_t rows [16] = '{
        '{16'h0000, 8'h90}, '{16'h001f, 8'haf}, '{16'h0200, 8'h40},
        '{16'h021f, 8'h5f}, '{16'h0226, 8'h66}, '{16'h0227, 8'h00},
        '{16'h0236, 8'h00}, '{16'h0237, 8'h77}, '{16'h0240, 8'h80},
        '{16'h0260, 8'h80}, '{16'h027e, 8'h9e}, '{16'h0280, 8'h00},
        '{16'h0fff, 8'h00}, '{16'h1000, 8'ha5}, '{16'h2fff, 8'h5a},
        '{16'h3000, 8'h00}};

    owm_core #(.FAMILY(FAM), .SERIAL(SER)) owm_core_i (.core_clk, .srst,
        .bus_reset, .bus_reset_std, .rx_valid, .rx_bit, .tx_req, .tx_valid,
        .tx_bit, .overdrive, .rom_done, .id_crc_ok, .id_crc, .cmd_valid,
        .cmd_byte, .mission_active, .spad_wr, .spad_off, .spad_data,
        .copy_req, .copy_page, .copy_busy, .copy_err, .cal_crc_ok, .rd_req,
        .rd_addr, .rd_valid, .rd_data, .log_wr, .log_addr, .log_data);
    owm_host owm_host_i (.core_clk, .bus_reset, .bus_reset_std, .rx_valid,
        .rx_bit, .tx_req, .tx_valid, .tx_bit);

    // clock and function byte counter
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (cmd_valid === 1'b1) cmd_seen++;

    // ==========================================================
    // shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
        end
        return c;
    endfunction : crc8

    // whole scratchpad page, last byte optionally the page crc
    task automatic fill(input logic [7:0] seed, input logic cal);
        logic [7:0] c, d;
        c = 8'h00;
        for (int i = 0; i < 32; i++) begin
            d = (cal && i == 31) ? c : seed + 8'(i);
            c = crc8(c, d);
            @(posedge core_clk);
            spad_wr <= 1'b1;
            spad_off <= 5'(i);
            spad_data <= d;
        end
        @(posedge core_clk);
        spad_wr <= 1'b0;
    endtask : fill

    task automatic copy(input logic [8:0] pg, input logic err);
        @(posedge core_clk);
        copy_req <= 1'b1;
        copy_page <= pg;
        @(posedge core_clk);
        copy_req <= 1'b0;
        #1;
        check(copy_err, err);
        check(copy_busy, !err);
        for (int n = 0; n < 40 && copy_busy !== 1'b0; n++) @(posedge core_clk);
        #1;
        if (copy_busy !== 1'b0) begin
            fails++;
            test_done();
        end
    endtask : copy

    task automatic rom_cmd(input logic [7:0] code, input logic [63:0] id);
        int n0;
        logic done;
        done = !(code == 8'h03 || code == 8'h04);
        owm_host_i.link_reset(1'b1);
        owm_host_i.send_byte(code);
        if (code == 8'h02 || code == 8'h07) begin
            for (int k = 0; k < 8; k++) owm_host_i.send_byte(id[8*k+:8]);
        end
        repeat (2) @(posedge core_clk);
        #1;
        check(rom_done, done);
        check(overdrive, code == 8'h06 || code == 8'h07);
        n0 = cmd_seen;
        owm_host_i.send_byte(8'ha0 + code);
        repeat (2) @(posedge core_clk);
        #1;
        check(cmd_seen - n0, done);
        if (done) check(cmd_byte, 8'ha0 + code);
    endtask : rom_cmd

    // ==========================================================
    // main sequence: reset, link layer, memory map
    initial begin
        logic [7:0] c;
        logic [63:0] id, got;
        logic ok;
        c = crc8(8'h00, FAM);
        for (int k = 0; k < 6; k++) c = crc8(c, SER[8*k+:8]);
        id = {c, SER, FAM};
        repeat (8) @(posedge core_clk);
        #1;
        check({tx_valid, rom_done, overdrive, id_crc_ok, copy_busy},
            5'h00);
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        repeat (70) @(posedge core_clk);
        #1;
        check(id_crc_ok, 1'b1);
        check(id_crc, c);
        $display("test reset done");
        owm_host_i.link_reset(1'b1);
        owm_host_i.send_byte(8'h01);
        owm_host_i.read_id(got, ok);
        check(ok, 1'b1);
        check(got, id);
        check(rom_done, 1'b1);
        if (ok !== 1'b1) test_done();
        for (int k = 2; k <= 8; k++) rom_cmd(8'(k), id);
        // enter overdrive, then a short link reset must keep it
        owm_host_i.link_reset(1'b1);
        owm_host_i.send_byte(8'h06);
        owm_host_i.link_reset(1'b0);
        #1;
        check(overdrive, 1'b1);
        $display("test link done");
        fill(8'h40, 1'b0);
        copy(9'h010, 1'b0);
        fill(8'h60, 1'b0);
        copy(9'h011, 1'b0);
        fill(8'h80, 1'b0);
        copy(9'h013, 1'b0);
        check(cal_crc_ok, 1'b0);
        fill(8'h80, 1'b1);
        copy(9'h012, 1'b0);
        check(cal_crc_ok, 1'b1);
        mission_active <= 1'b1;
        fill(8'h90, 1'b0);
        copy(9'h010, 1'b1);
        copy(9'h011, 1'b1);
        copy(9'h014, 1'b1);
        copy(9'h080, 1'b1);
        copy(9'h000, 1'b0);
        @(posedge core_clk);
        log_wr <= 1'b1;
        log_data <= 8'ha5;
        @(posedge core_clk);
        log_addr <= 13'h1fff;
        log_data <= 8'h5a;
        @(posedge core_clk);
        log_wr <= 1'b0;
        for (int r = 0; r < 16; r++) begin
            @(posedge core_clk);
            rd_req <= 1'b1;
            rd_addr <= rows[r].a;
            @(posedge core_clk);
            rd_req <= 1'b0;
            #1;
            check(rd_valid, 1'b1);
            check(rd_data, rows[r].d);
        end
        $display("test memory done");
        // mid-run reset clears overdrive and reruns the crc self-check
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        check({overdrive, rom_done, id_crc_ok, copy_busy}, 4'h0);
        repeat (70) @(posedge core_clk);
        #1;
        check(id_crc_ok, 1'b1);
        check(id_crc, c);
        $display("test second reset done");
        test_done();
    end
endmodule : onewire_rom_id_and_memory_map_tb_top
`default_nettype wire
